// >>> hw/rsc_pkg.sv
package rsc_pkg;
    localparam logic [7:0] RSC_PORT_DEFAULT = 8'hff;
    localparam logic [7:0] RSC_RSTSEL_DEFAULT = 8'h55;
    localparam logic [7:0] RSC_LVSEL_DEFAULT = 8'h66;
    localparam logic [7:0] RSC_ZERO_BYTE = 8'h00;

    typedef enum logic [2:0] {
        RSC_NONE,
        RSC_POWER_ON,
        RSC_PIN,
        RSC_LOW_VOLT,
        RSC_WDT_NORMAL,
        RSC_WDT_IDLE
    } rsc_kind_e;

    typedef struct packed {
        logic watchdog_timeout_flag;
        logic powerdown_flag;
        logic lv_reset_cause_flag;
        logic [7:0] reset_pin_select_reg;
        logic [7:0] lv_level_select_reg;
        logic [7:0] portData;
        logic [7:0] portDir;
        logic [7:0] muldiv_work_reg;
        logic timersOn;
        logic intEnable;
        logic clearPc;
        logic clearSp;
        logic stackTop;
        logic clearWdt;
        logic initDone;
        logic [1:0] pinSync;
        logic [1:0] lvSync;
        rsc_kind_e lastKind;
    } rsc_state_s;
endpackage : rsc_pkg

// >>> hw/rsc_reset_state_controller.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_state_controller (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic powerOnReq,
    input wire logic external_reset_pin,
    input wire logic low_voltage_reset,
    input wire logic watchdog_timer,
    input wire logic idleMode,
    input wire logic sleepEntry,
    input wire logic clearWatchdogCmd,
    input wire logic swClearLvFlag,
    input wire logic swWrite,
    input wire logic [7:0] swRstSel,
    input wire logic [7:0] swLvSel,
    input wire logic [7:0] swPortData,
    input wire logic [7:0] swPortDir,
    input wire logic [7:0] swMulDiv,
    input wire logic swTimersOn,
    input wire logic swIntEnable,
    output logic watchdog_timeout_flag,
    output logic powerdown_flag,
    output logic lv_reset_cause_flag,
    output logic [7:0] reset_pin_select_reg,
    output logic [7:0] lv_level_select_reg,
    output logic [7:0] portData,
    output logic [7:0] portDir,
    output logic [7:0] muldiv_work_reg,
    output logic timersOn,
    output logic intEnable,
    output logic clearPc,
    output logic clearSp,
    output logic stackTop,
    output logic clearWdt
);
    // ---------------------------------------------------------------
    // Reset pin and low-voltage synchronisers.
    // ---------------------------------------------------------------
    rsc_pkg::rsc_state_s st;
    rsc_pkg::rsc_state_s next_st;
    logic pinReq;
    logic lvReq;
    assign pinReq = st.pinSync[1];
    assign lvReq = st.lvSync[1];

    // ---------------------------------------------------------------
    // Reset kind decode, highest priority first.
    // ---------------------------------------------------------------
    rsc_pkg::rsc_kind_e kind;
    always_comb begin
        if (powerOnReq || !st.initDone) begin
            kind = rsc_pkg::RSC_POWER_ON;
        end else if (pinReq) begin
            kind = rsc_pkg::RSC_PIN;
        end else if (lvReq && !idleMode) begin
            kind = rsc_pkg::RSC_LOW_VOLT;
        end else if (watchdog_timer && idleMode) begin
            kind = rsc_pkg::RSC_WDT_IDLE;
        end else if (watchdog_timer) begin
            kind = rsc_pkg::RSC_WDT_NORMAL;
        end else begin
            kind = rsc_pkg::RSC_NONE;
        end
    end

    // ---------------------------------------------------------------
    // Next state.
    // ---------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.lastKind = kind;
        next_st.clearPc = 1'b0;
        next_st.clearSp = 1'b0;
        next_st.stackTop = 1'b0;
        next_st.clearWdt = clearWatchdogCmd;
        if (swWrite) begin
            next_st.reset_pin_select_reg = swRstSel;
            next_st.lv_level_select_reg = swLvSel;
            next_st.portData = swPortData;
            next_st.portDir = swPortDir;
            next_st.muldiv_work_reg = swMulDiv;
            next_st.timersOn = swTimersOn;
            next_st.intEnable = swIntEnable;
        end
        if (swClearLvFlag) begin
            next_st.lv_reset_cause_flag = 1'b0;
        end
        if (sleepEntry) begin
            next_st.powerdown_flag = 1'b1;
            next_st.watchdog_timeout_flag = 1'b0;
        end
        case (kind)
            rsc_pkg::RSC_POWER_ON, rsc_pkg::RSC_PIN, rsc_pkg::RSC_LOW_VOLT,
            rsc_pkg::RSC_WDT_NORMAL: begin
                next_st.clearPc = 1'b1;
                next_st.clearSp = 1'b1;
                next_st.stackTop = 1'b1;
                next_st.clearWdt = 1'b1;
                next_st.intEnable = 1'b0;
                next_st.timersOn = 1'b0;
                next_st.portData = rsc_pkg::RSC_PORT_DEFAULT;
                next_st.portDir = rsc_pkg::RSC_PORT_DEFAULT;
                next_st.reset_pin_select_reg = rsc_pkg::RSC_RSTSEL_DEFAULT;
                next_st.muldiv_work_reg = rsc_pkg::RSC_ZERO_BYTE;
                if (kind != rsc_pkg::RSC_LOW_VOLT) begin
                    next_st.lv_level_select_reg = rsc_pkg::RSC_LVSEL_DEFAULT;
                end else begin
                    next_st.lv_reset_cause_flag = 1'b1;
                end
                if (kind == rsc_pkg::RSC_POWER_ON) begin
                    next_st.watchdog_timeout_flag = 1'b0;
                    next_st.powerdown_flag = 1'b0;
                    next_st.initDone = 1'b1;
                end else if (kind == rsc_pkg::RSC_WDT_NORMAL) begin
                    next_st.watchdog_timeout_flag = 1'b1;
                    next_st.powerdown_flag = st.powerdown_flag;
                end else begin
                    next_st.watchdog_timeout_flag = st.watchdog_timeout_flag;
                    next_st.powerdown_flag = st.powerdown_flag;
                end
            end
            rsc_pkg::RSC_WDT_IDLE: begin
                next_st = st;
                next_st.lastKind = kind;
                next_st.clearWdt = 1'b0;
                next_st.clearPc = 1'b1;
                next_st.clearSp = 1'b1;
                next_st.stackTop = 1'b0;
                next_st.watchdog_timeout_flag = 1'b1;
                next_st.powerdown_flag = 1'b1;
            end
            default: begin
            end
        endcase
        next_st.pinSync = {st.pinSync[0], ~external_reset_pin};
        next_st.lvSync = {st.lvSync[0], low_voltage_reset};
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign watchdog_timeout_flag = st.watchdog_timeout_flag;
    assign powerdown_flag = st.powerdown_flag;
    assign lv_reset_cause_flag = st.lv_reset_cause_flag;
    assign reset_pin_select_reg = st.reset_pin_select_reg;
    assign lv_level_select_reg = st.lv_level_select_reg;
    assign portData = st.portData;
    assign portDir = st.portDir;
    assign muldiv_work_reg = st.muldiv_work_reg;
    assign timersOn = st.timersOn;
    assign intEnable = st.intEnable;
    assign clearPc = st.clearPc;
    assign clearSp = st.clearSp;
    assign stackTop = st.stackTop;
    assign clearWdt = st.clearWdt;

    // ---------------------------------------------------------------
    // Checks.
    // ---------------------------------------------------------------
    sequence s_wdtNormal;
        st.lastKind == rsc_pkg::RSC_WDT_NORMAL;
    endsequence
    sequence s_wdtIdle;
        st.lastKind == rsc_pkg::RSC_WDT_IDLE;
    endsequence

    a_normal_wdt_flag: assert property (@(posedge clk) disable iff (!rst_n)
        s_wdtNormal |-> watchdog_timeout_flag && portDir == 8'hff && clearPc)
        else $error("normal watchdog reset wrong");
    a_idle_wdt_keep: assert property (@(posedge clk) disable iff (!rst_n)
        s_wdtIdle |-> clearPc && clearSp && portData == $past(portData))
        else $error("idle watchdog reset wrong");
    a_idle_both_flags: assert property (@(posedge clk) disable iff (!rst_n)
        s_wdtIdle |-> watchdog_timeout_flag && powerdown_flag)
        else $error("idle watchdog flags wrong");
    a_por_flags_clear: assert property (@(posedge clk) disable iff (!rst_n)
        st.lastKind == rsc_pkg::RSC_POWER_ON |-> !watchdog_timeout_flag && !powerdown_flag)
        else $error("power-on flags wrong");
    a_normal_pdf_keep: assert property (@(posedge clk) disable iff (!rst_n)
        s_wdtNormal |-> powerdown_flag == $past(powerdown_flag))
        else $error("powerdown flag changed");
    a_pin_flags_keep: assert property (@(posedge clk) disable iff (!rst_n)
        st.lastKind == rsc_pkg::RSC_PIN |->
        watchdog_timeout_flag == $past(watchdog_timeout_flag))
        else $error("pin reset changed timeout");
    a_por_defaults: assert property (@(posedge clk) disable iff (!rst_n)
        st.lastKind == rsc_pkg::RSC_POWER_ON |->
        !timersOn && !intEnable && reset_pin_select_reg == 8'h55 && stackTop)
        else $error("power-on defaults wrong");
    a_lv_keep_sel: assert property (@(posedge clk) disable iff (!rst_n)
        st.lastKind == rsc_pkg::RSC_LOW_VOLT |->
        lv_reset_cause_flag && lv_level_select_reg == $past(lv_level_select_reg))
        else $error("low-voltage reset wrong");
    a_sleep_flags: assert property (@(posedge clk) disable iff (!rst_n)
        st.initDone && st.lastKind == rsc_pkg::RSC_NONE && $past(sleepEntry) |->
        powerdown_flag && !watchdog_timeout_flag)
        else $error("sleep entry flags wrong");
    a_lv_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
        st.initDone && st.lastKind == rsc_pkg::RSC_NONE && $past(swClearLvFlag) |->
        !lv_reset_cause_flag)
        else $error("low-voltage flag not cleared");
    a_idle_no_restart: assert property (@(posedge clk) disable iff (!rst_n)
        s_wdtIdle |-> !clearWdt && !stackTop && timersOn == $past(timersOn))
        else $error("idle watchdog restarted blocks");
    a_pin_restart: assert property (@(posedge clk) disable iff (!rst_n)
        st.lastKind == rsc_pkg::RSC_PIN |->
        clearPc && lv_level_select_reg == rsc_pkg::RSC_LVSEL_DEFAULT)
        else $error("pin reset restart wrong");
endmodule : rsc_reset_state_controller
`default_nettype wire

// >>> testbench/rsc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_core_model (
    input wire logic clk,
    input wire logic clearPc,
    input wire logic clearSp,
    output logic [7:0] pc,
    output logic [7:0] sp
);
    // Core restarts at address zero and stack at zero on a clear pulse.
    always_ff @(posedge clk) begin
        pc <= clearPc ? 8'h00 : pc + 8'h01;
        sp <= clearSp ? 8'h00 : sp;
    end
endmodule : rsc_core_model
`default_nettype wire

// >>> testbench/rsc_reset_state_controller_test.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_state_controller_test;
    logic clk = 1'b0, rst_n = 1'b0, pwr = 1'b0, pin = 1'b1, lv = 1'b0, wdt = 1'b0;
    logic idle = 1'b0, slp = 1'b0, clrW = 1'b0, clrLv = 1'b0, wr = 1'b0, swT = 1'b0;
    logic swI = 1'b0;
    logic [7:0] swR = 8'h00, swL = 8'h00, swD = 8'h00, swP = 8'h00, swM = 8'h00;
    logic to, pd, lvf, tOn, iEn, cPc, cSp, sTop, cWdt;
    logic [7:0] rSel, lSel, pDat, pDir, mWr, pc, sp;
    int mismatches = 0, checks_done = 0;
    rsc_reset_state_controller rsc_reset_state_controller_inst (
        .clk(clk), .rst_n(rst_n), .powerOnReq(pwr), .external_reset_pin(pin),
        .low_voltage_reset(lv), .watchdog_timer(wdt), .idleMode(idle), .sleepEntry(slp),
        .clearWatchdogCmd(clrW), .swClearLvFlag(clrLv), .swWrite(wr), .swRstSel(swR),
        .swLvSel(swL), .swPortData(swD), .swPortDir(swP), .swMulDiv(swM),
        .swTimersOn(swT), .swIntEnable(swI), .watchdog_timeout_flag(to),
        .powerdown_flag(pd), .lv_reset_cause_flag(lvf), .reset_pin_select_reg(rSel),
        .lv_level_select_reg(lSel), .portData(pDat), .portDir(pDir),
        .muldiv_work_reg(mWr), .timersOn(tOn), .intEnable(iEn), .clearPc(cPc),
        .clearSp(cSp), .stackTop(sTop), .clearWdt(cWdt));
    rsc_core_model rsc_core_model_inst (.clk(clk), .clearPc(cPc), .clearSp(cSp),
        .pc(pc), .sp(sp));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic fl(input logic t, input logic p);
        chk("timeout", {7'h00, t}, {7'h00, to});
        chk("powerDown", {7'h00, p}, {7'h00, pd});
    endtask : fl
    task automatic dflt(input logic [7:0] l);
        chk("rstSel", 8'h55, rSel);
        chk("lvSel", l, lSel);
        chk("portData", 8'hff, pDat);
        chk("portDir", 8'hff, pDir);
        chk("mulDiv", 8'h00, mWr);
        chk("timers", 8'h00, {7'h00, tOn});
        chk("intEn", 8'h00, {7'h00, iEn});
    endtask : dflt
    task automatic hit(input logic full);
        int n;
        n = 0;
        while (cPc !== 1'b1 && n < 6) begin
            step();
            n++;
        end
        chk("clearPc", 8'h01, {7'h00, cPc});
        chk("clearSp", 8'h01, {7'h00, cSp});
        chk("stackTop", {7'h00, full}, {7'h00, sTop});
        chk("clearWdt", {7'h00, full}, {7'h00, cWdt});
        step();
        chk("pc", 8'h00, pc);
        chk("sp", 8'h00, sp);
        chk("pulseEnd", 8'h00, {7'h00, cPc});
    endtask : hit
    task automatic wrAll();
        {swR, swL, swD, swP, swM, swT, swI, wr} = {40'haa330f3c5a, 3'b111};
        step();
        wr = 1'b0;
    endtask : wrAll
    task automatic tPower();
        step(2);
        fl(1'b0, 1'b0);
        dflt(8'h66);
        chk("pc", 8'h00, pc);
        chk("sp", 8'h00, sp);
        clrW = 1'b1;
        step();
        clrW = 1'b0;
        chk("clearWdt", 8'h01, {7'h00, cWdt});
        step();
        chk("clearWdt", 8'h00, {7'h00, cWdt});
        $display("test power-on done");
    endtask : tPower
    task automatic tWdtNormal();
        wrAll();
        slp = 1'b1;
        step();
        slp = 1'b0;
        fl(1'b0, 1'b1);
        wdt = 1'b1;
        step();
        wdt = 1'b0;
        hit(1'b1);
        fl(1'b1, 1'b1);
        dflt(8'h66);
        $display("test normal watchdog done");
    endtask : tWdtNormal
    task automatic tWdtIdle();
        wrAll();
        idle = 1'b1;
        slp = 1'b1;
        step();
        slp = 1'b0;
        fl(1'b0, 1'b1);
        wdt = 1'b1;
        step();
        wdt = 1'b0;
        hit(1'b0);
        idle = 1'b0;
        fl(1'b1, 1'b1);
        chk("rstSel", 8'haa, rSel);
        chk("portData", 8'h0f, pDat);
        chk("mulDiv", 8'h5a, mWr);
        chk("timers", 8'h01, {7'h00, tOn});
        chk("intEn", 8'h01, {7'h00, iEn});
        $display("test idle watchdog done");
    endtask : tWdtIdle
    task automatic tPin();
        wrAll();
        pin = 1'b0;
        step();
        pin = 1'b1;
        hit(1'b1);
        fl(1'b1, 1'b1);
        dflt(8'h66);
        $display("test pin done");
    endtask : tPin
    task automatic tLowVolt();
        wrAll();
        lv = 1'b1;
        step();
        lv = 1'b0;
        hit(1'b1);
        chk("lvFlag", 8'h01, {7'h00, lvf});
        dflt(8'h33);
        fl(1'b1, 1'b1);
        clrLv = 1'b1;
        step();
        clrLv = 1'b0;
        chk("lvFlag", 8'h00, {7'h00, lvf});
        idle = 1'b1;
        lv = 1'b1;
        step(4);
        lv = 1'b0;
        step(3);
        idle = 1'b0;
        chk("lvFlag", 8'h00, {7'h00, lvf});
        chk("lvSel", 8'h33, lSel);
        pwr = 1'b1;
        step();
        pwr = 1'b0;
        hit(1'b1);
        fl(1'b0, 1'b0);
        dflt(8'h66);
        $display("test low voltage done");
    endtask : tLowVolt
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    initial begin
        step(2);
        rst_n = 1'b1;
        tPower();
        tWdtNormal();
        tWdtIdle();
        tPin();
        tLowVolt();
        test_done();
    end
    initial begin
        repeat (600) @(posedge clk);
        mismatches++;
        test_done();
    end
endmodule : rsc_reset_state_controller_test
`default_nettype wire
